// [rtl/wgt_timer_regs.vh]
// Purpose: Register map, field positions and timing constants of the
//          wake-up and general purpose timer block.
// Assumes: 20 MHz system clock, APB with 32-bit data.
// Notes:   Register index = byte address / 4.
`ifndef WGT_TIMER_REGS_VH
`define WGT_TIMER_REGS_VH

// ============================================================
// Register indices
`define WGT_IDX_WAKE_INTERVAL_LOW   8'h30
`define WGT_IDX_AWAKE_HOLD_PERIOD   8'h31
`define WGT_IDX_GP_TIMER_CONFIG     8'h32
`define WGT_IDX_GP_TIMER_PRESCALE   8'h33
`define WGT_IDX_GP_TIMER_ONE_PERIOD 8'h34
`define WGT_IDX_GP_TIMER_TWO_PERIOD 8'h35
`define WGT_IDX_WAKE_CTRL           8'h40
`define WGT_IDX_WAKE_PRESCALE       8'h41
`define WGT_IDX_WAKE_INTERVAL_HIGH  8'h42
`define WGT_IDX_INT_STATUS          8'h48
`define WGT_IDX_INT_ENABLE          8'h49
`define WGT_IDX_INT_CLEAR           8'h4a

// ============================================================
// Reset values
`define WGT_RST_BYTE 8'h00
`define WGT_RST_NIB  4'h0

// ============================================================
// Field positions
`define WGT_CFG_ONE_RUN  0
`define WGT_CFG_ONE_SRC  1
`define WGT_CFG_TWO_RUN  4
`define WGT_CFG_TWO_SRC  5
`define WGT_CTL_WAKE_SRC 0
`define WGT_CTL_WAKE_EN  1
`define WGT_CTL_HOLD_EN  2
`define WGT_EV_WAKE      0
`define WGT_EV_HOLD      1
`define WGT_EV_ONE       2
`define WGT_EV_TWO       3

// ============================================================
// Prescaler encoding
`define WGT_PS_SHIFT_BASE 4'h6
`define WGT_GT_MAX_CODE   4'h9
`define WGT_WU_MAX_CODE   4'h7
`define WGT_GT_LIMIT_TOP  16'hffff
`define WGT_WU_LIMIT_TOP  16'h3fff

// ============================================================
// Timing
`define WGT_CLK_HZ      20000000
`define WGT_FAST_HZ     2000000
`define WGT_FAST_DIV    (`WGT_CLK_HZ / `WGT_FAST_HZ)
`define WGT_RC_DIV      610

`endif

// [rtl/wgt_prescaler.v]
// Purpose: Divides a tick stream by the encoded prescale factor.
// Assumes: tick_i is a one-cycle pulse on clk_i.
// Notes:   Progress is held while run_i is low; clr_i restarts it.
`timescale 1ns/1ps
`include "wgt_timer_regs.vh"

module wgt_prescaler (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // Control
  input wire tick_i,
  input wire run_i,
  input wire clr_i,
  input wire gt_code_i,
  input wire [3:0] code_i,
  // Divided tick
  output reg tick_o
);

  reg [15:0] cnt_r;
  wire [15:0] limit;

  // ==========================================================
  // Terminal count of the divider
  function [15:0] wgt_limit;
    input [3:0] code;
    input gt;
    begin
      if (code == `WGT_RST_NIB) begin
        wgt_limit = 16'h0000;
      end else if ((gt && code <= `WGT_GT_MAX_CODE) ||
                   (!gt && code <= `WGT_WU_MAX_CODE)) begin
        wgt_limit = (16'h0001 << (code + `WGT_PS_SHIFT_BASE)) - 16'h0001;
      end else if (gt) begin
        wgt_limit = `WGT_GT_LIMIT_TOP;
      end else begin
        wgt_limit = `WGT_WU_LIMIT_TOP;
      end
    end
  endfunction

  assign limit = wgt_limit(code_i, gt_code_i);

  // ==========================================================
  // Divider
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end else if (clr_i) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (run_i && tick_i) begin
        if (cnt_r >= limit) begin
          cnt_r <= 16'h0000;
          tick_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

endmodule // wgt_prescaler

// [rtl/wgt_timer_top.v]
// Purpose: Wake-up timer, post-wake hold timer and two general purpose
//          timers behind an APB register file.
// Assumes: 20 MHz clk_i; external slow clock arrives asynchronously.
// Notes:   One wait state on every APB access.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "wgt_timer_regs.vh"

module wgt_timer_top #(
  parameter RC_DIV = `WGT_RC_DIV
) (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // External slow clock pin
  input wire external_slow_clock_in_i,
  // Events and status
  output reg irq_o,
  output reg wake_event_o,
  output reg awake_active_o,
  output reg timer_one_done_o,
  output reg timer_two_done_o
);

  localparam integer FAST_DIV_INT = `WGT_FAST_DIV - 1;
  localparam integer RC_DIV_INT = RC_DIV - 1;
  localparam [3:0] FAST_DIV_M1 = FAST_DIV_INT[3:0];
  localparam [15:0] RC_DIV_M1 = RC_DIV_INT[15:0];

  // ==========================================================
  // Registers
  reg [7:0] wake_interval_low_r;
  reg [7:0] wake_interval_high_r;
  reg [7:0] awake_hold_period_r;
  reg [7:0] gp_timer_config_r;
  reg [7:0] gp_timer_prescale_r;
  reg [7:0] gp_timer_one_period_r;
  reg [7:0] gp_timer_two_period_r;
  reg [7:0] wake_prescale_r;
  reg [2:0] wake_ctrl_r;
  reg [3:0] int_status_r;
  reg [3:0] int_enable_r;
  // Clock generation state
  reg ext_sync1_r;
  reg ext_sync2_r;
  reg ext_prev_r;
  reg [15:0] rc_cnt_r;
  reg rc_tick_r;
  reg [3:0] fast_cnt_r;
  reg fast_tick_r;
  // Timer state
  reg [15:0] wake_cnt_r;
  reg [7:0] hold_cnt_r;
  reg hold_active_r;
  reg [7:0] one_cnt_r;
  reg [7:0] two_cnt_r;

  // ==========================================================
  // Bus decode
  wire [7:0] idx = paddr_i[9:2];
  wire addr_ok_hi = (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00);
  wire xfer_done = psel_i && penable_i && pready_o;
  wire wr_en = xfer_done && pwrite_i;
  wire wr_ok = wr_en && addr_ok_hi;
  wire [7:0] wbyte = pwdata_i[7:0];
  wire [31:0] rd_word;
  wire rd_hit;
  reg [7:0] rd_byte;
  reg rd_map;
  function wgt_reached;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      wgt_reached = (cnt >= lim);
    end
  endfunction
  function [15:0] wgt_gt_lim;
    input [7:0] period;
    begin
      if (period == `WGT_RST_BYTE) begin
        wgt_gt_lim = 16'h0000;
      end else begin
        wgt_gt_lim = {8'h00, period - 8'h01};
      end
    end
  endfunction
  always @* begin
    rd_byte = `WGT_RST_BYTE;
    rd_map = 1'b1;
    case (idx)
      `WGT_IDX_WAKE_INTERVAL_LOW: rd_byte = wake_interval_low_r;
      `WGT_IDX_AWAKE_HOLD_PERIOD: rd_byte = awake_hold_period_r;
      `WGT_IDX_GP_TIMER_CONFIG: rd_byte = gp_timer_config_r;
      `WGT_IDX_GP_TIMER_PRESCALE: rd_byte = gp_timer_prescale_r;
      `WGT_IDX_GP_TIMER_ONE_PERIOD: rd_byte = gp_timer_one_period_r;
      `WGT_IDX_GP_TIMER_TWO_PERIOD: rd_byte = gp_timer_two_period_r;
      `WGT_IDX_WAKE_CTRL: rd_byte = {5'h00, wake_ctrl_r};
      `WGT_IDX_WAKE_PRESCALE: rd_byte = wake_prescale_r;
      `WGT_IDX_WAKE_INTERVAL_HIGH: rd_byte = wake_interval_high_r;
      `WGT_IDX_INT_STATUS: rd_byte = {4'h0, int_status_r};
      `WGT_IDX_INT_ENABLE: rd_byte = {4'h0, int_enable_r};
      `WGT_IDX_INT_CLEAR: rd_byte = `WGT_RST_BYTE;
      default: rd_map = 1'b0;
    endcase
  end

  assign rd_hit = rd_map && addr_ok_hi;
  assign rd_word = {24'h000000, rd_byte};

  // ==========================================================
  // APB answer: one wait state, data and error registered
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !rd_hit;
      if (psel_i && penable_i && !pready_o) begin
        prdata_o <= (rd_hit && !pwrite_i) ? rd_word : 32'h00000000;
      end
    end
  end

  // ==========================================================
  // Clock sources
  // Slow pin synchroniser, then edge detect on the second stage
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_sync1_r <= 1'b0;
      ext_sync2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_sync1_r <= external_slow_clock_in_i;
      ext_sync2_r <= ext_sync1_r;
      ext_prev_r <= ext_sync2_r;
    end
  end

  // On-chip RC oscillator stand-in
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_cnt_r <= 16'h0000;
      rc_tick_r <= 1'b0;
    end else if (rc_cnt_r >= RC_DIV_M1) begin
      rc_cnt_r <= 16'h0000;
      rc_tick_r <= 1'b1;
    end else begin
      rc_cnt_r <= rc_cnt_r + 16'h0001;
      rc_tick_r <= 1'b0;
    end
  end

  // 2 MHz tick
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fast_cnt_r <= 4'h0;
      fast_tick_r <= 1'b0;
    end else if (fast_cnt_r >= FAST_DIV_M1) begin
      fast_cnt_r <= 4'h0;
      fast_tick_r <= 1'b1;
    end else begin
      fast_cnt_r <= fast_cnt_r + 4'h1;
      fast_tick_r <= 1'b0;
    end
  end

  wire ext_tick = ext_sync2_r && !ext_prev_r;
  wire wake_src_rc = wake_ctrl_r[`WGT_CTL_WAKE_SRC];
  wire wake_tick = wake_src_rc ? rc_tick_r : ext_tick;
  wire one_src = gp_timer_config_r[`WGT_CFG_ONE_SRC] ? fast_tick_r
                                                     : wake_tick;
  wire two_src = gp_timer_config_r[`WGT_CFG_TWO_SRC] ? fast_tick_r
                                                     : wake_tick;

  // ==========================================================
  // Prescalers
  wire wake_en = wake_ctrl_r[`WGT_CTL_WAKE_EN];
  wire one_run = gp_timer_config_r[`WGT_CFG_ONE_RUN];
  wire two_run = gp_timer_config_r[`WGT_CFG_TWO_RUN];
  wire wake_ps_tick;
  wire hold_ps_tick;
  wire one_ps_tick;
  wire two_ps_tick;
  wire wake_to;
  wire hold_to;
  wire one_to;
  wire two_to;
  wgt_prescaler u_wake_ps (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(wake_tick),
    .run_i(wake_en),
    .clr_i(!wake_en),
    .gt_code_i(1'b0),
    .code_i(wake_prescale_r[3:0]),
    .tick_o(wake_ps_tick)
  );
  wgt_prescaler u_hold_ps (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(wake_tick),
    .run_i(hold_active_r),
    .clr_i(!hold_active_r),
    .gt_code_i(1'b0),
    .code_i(wake_prescale_r[7:4]),
    .tick_o(hold_ps_tick)
  );
  wgt_prescaler u_one_ps (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(one_src),
    .run_i(one_run),
    .clr_i(one_to),
    .gt_code_i(1'b1),
    .code_i(gp_timer_prescale_r[3:0]),
    .tick_o(one_ps_tick)
  );
  wgt_prescaler u_two_ps (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(two_src),
    .run_i(two_run),
    .clr_i(two_to),
    .gt_code_i(1'b1),
    .code_i(gp_timer_prescale_r[7:4]),
    .tick_o(two_ps_tick)
  );
  wire [15:0] wake_lim = {wake_interval_high_r, wake_interval_low_r};
  assign wake_to = wake_en && wake_ps_tick &&
                   wgt_reached(wake_cnt_r, wake_lim);
  assign hold_to = hold_active_r && hold_ps_tick &&
                   wgt_reached({8'h00, hold_cnt_r},
                               {8'h00, awake_hold_period_r});
  assign one_to = one_run && one_ps_tick &&
                  wgt_reached({8'h00, one_cnt_r},
                              wgt_gt_lim(gp_timer_one_period_r));
  assign two_to = two_run && two_ps_tick &&
                  wgt_reached({8'h00, two_cnt_r},
                              wgt_gt_lim(gp_timer_two_period_r));

  // ==========================================================
  // Period counters; paused GP timers hold their count; wake and hold counters clear when off
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_cnt_r <= 16'h0000;
      hold_cnt_r <= `WGT_RST_BYTE;
      hold_active_r <= 1'b0;
      one_cnt_r <= `WGT_RST_BYTE;
      two_cnt_r <= `WGT_RST_BYTE;
    end else begin
      if (!wake_en || wake_to) begin
        wake_cnt_r <= 16'h0000;
      end else if (wake_ps_tick) begin
        wake_cnt_r <= wake_cnt_r + 16'h0001;
      end
      if (hold_to) begin
        hold_active_r <= 1'b0;
      end else if (wake_to && wake_ctrl_r[`WGT_CTL_HOLD_EN]) begin
        hold_active_r <= 1'b1;
      end
      if (!hold_active_r || hold_to) begin
        hold_cnt_r <= `WGT_RST_BYTE;
      end else if (hold_ps_tick) begin
        hold_cnt_r <= hold_cnt_r + 8'h01;
      end
      if (one_to) begin
        one_cnt_r <= `WGT_RST_BYTE;
      end else if (one_run && one_ps_tick) begin
        one_cnt_r <= one_cnt_r + 8'h01;
      end
      if (two_to) begin
        two_cnt_r <= `WGT_RST_BYTE;
      end else if (two_run && two_ps_tick) begin
        two_cnt_r <= two_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Software registers
  wire [7:0] cfg_after_to = gp_timer_config_r &
    ~({7'h00, one_to} << `WGT_CFG_ONE_RUN) &
    ~({7'h00, two_to} << `WGT_CFG_TWO_RUN);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_interval_low_r <= `WGT_RST_BYTE;
      wake_interval_high_r <= `WGT_RST_BYTE;
      awake_hold_period_r <= `WGT_RST_BYTE;
      gp_timer_config_r <= `WGT_RST_BYTE;
      gp_timer_prescale_r <= `WGT_RST_BYTE;
      gp_timer_one_period_r <= `WGT_RST_BYTE;
      gp_timer_two_period_r <= `WGT_RST_BYTE;
      wake_prescale_r <= `WGT_RST_BYTE;
      wake_ctrl_r <= 3'b000;
      int_enable_r <= `WGT_RST_NIB;
    end else begin
      // A write in the time-out cycle wins: software restarts
      gp_timer_config_r <= cfg_after_to;
      if (wr_ok) begin
        case (idx)
          `WGT_IDX_WAKE_INTERVAL_LOW: wake_interval_low_r <= wbyte;
          `WGT_IDX_WAKE_INTERVAL_HIGH: wake_interval_high_r <= wbyte;
          `WGT_IDX_AWAKE_HOLD_PERIOD: awake_hold_period_r <= wbyte;
          `WGT_IDX_GP_TIMER_CONFIG: gp_timer_config_r <= wbyte;
          `WGT_IDX_GP_TIMER_PRESCALE: gp_timer_prescale_r <= wbyte;
          `WGT_IDX_GP_TIMER_ONE_PERIOD: gp_timer_one_period_r <= wbyte;
          `WGT_IDX_GP_TIMER_TWO_PERIOD: gp_timer_two_period_r <= wbyte;
          `WGT_IDX_WAKE_PRESCALE: wake_prescale_r <= wbyte;
          `WGT_IDX_WAKE_CTRL: wake_ctrl_r <= wbyte[2:0];
          `WGT_IDX_INT_ENABLE: int_enable_r <= wbyte[3:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Interrupt status: new events win over a clear
  wire [3:0] events = {two_to, one_to, hold_to, wake_to};
  wire [3:0] clr_mask = (wr_ok && idx == `WGT_IDX_INT_CLEAR) ? wbyte[3:0]
                                                            : 4'h0;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_status_r <= `WGT_RST_NIB;
      irq_o <= 1'b0;
      wake_event_o <= 1'b0;
      awake_active_o <= 1'b0;
      timer_one_done_o <= 1'b0;
      timer_two_done_o <= 1'b0;
    end else begin
      int_status_r <= (int_status_r & ~clr_mask) | events;
      irq_o <= |(int_status_r & int_enable_r);
      wake_event_o <= events[`WGT_EV_WAKE];
      awake_active_o <= hold_active_r;
      timer_one_done_o <= events[`WGT_EV_ONE];
      timer_two_done_o <= events[`WGT_EV_TWO];
    end
  end

endmodule // wgt_timer_top

// [tb/wgt_timer_sva.sv]
// Purpose: Port-level checks of the timer block.
// Assumes: Bound to wgt_timer_top; one clock domain.
// Notes:   APB answers with one wait state.
`timescale 1ns/1ps
module wgt_timer_sva (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Events
  input wire irq_o,
  input wire wake_event_o,
  input wire timer_one_done_o,
  input wire timer_two_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // =====
  // Bus phases
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  a_ready_when_sel: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_align: assert property (pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o)
    else $error("misaligned access not refused");
  a_err_unmapped: assert property (pready_o && paddr_i[9:2] == 8'h3f
    |-> pslverr_o) else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready_o && paddr_i[11:10] == 2'b00 &&
    paddr_i[1:0] == 2'b00 && paddr_i[9:2] >= 8'h30 && paddr_i[9:2] <= 8'h35
    |-> !pslverr_o) else $error("mapped access refused");
  a_rdata_upper: assert property (pready_o && !pwrite_i
    |-> prdata_o[31:8] == 24'h0) else $error("read data upper bits set");
  a_one_pulse: assert property (timer_one_done_o |=> !timer_one_done_o)
    else $error("timer one done too long");
  a_two_pulse: assert property (timer_two_done_o |=> !timer_two_done_o)
    else $error("timer two done too long");
  a_reset_quiet: assert property ($rose(arst_n_i) |-> !pready_o && !irq_o &&
    !wake_event_o && !timer_one_done_o && !timer_two_done_o)
    else $error("output active after reset");
endmodule // wgt_timer_sva

bind wgt_timer_top wgt_timer_sva chk_u (.clk_i, .arst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .irq_o,
  .wake_event_o, .timer_one_done_o, .timer_two_done_o);

// [tb/tb.sv]
// Purpose: Self-checking bench of the timer block.
// Assumes: 20 MHz clock; external slow pin rises every 20 clocks.
// Notes:   GP and wake periods measured from one time-out to the next; hold and pause spans from their start.
`timescale 1ns/1ps
`include "wgt_timer_regs.vh"
module tb;
  logic clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, err, ext_i = 0, ext_on = 0;
  logic irq_o, wake_o, awake_o, t1_done, t2_done;
  int err_total = 0, n_tests = 0, cyc = 0;
  wire [3:0] ev = {awake_o, wake_o, t2_done, t1_done};
  wgt_timer_top #(.RC_DIV(4)) dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .external_slow_clock_in_i(ext_i), .irq_o(irq_o), .wake_event_o(wake_o),
    .awake_active_o(awake_o), .timer_one_done_o(t1_done),
    .timer_two_done_o(t2_done));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  always begin
    repeat (10) @(posedge clk_i);
    if (ext_on) ext_i <= ~ext_i;
  end
  // =====
  // Reporting
  task stop_test;
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_span(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // =====
  // Bus access
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask
  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
    chk_val(rd, {24'h0, exp});
  endtask
  task wait_ev(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ev[k] !== 1'b1 && n < lim);
  endtask
  // =====
  // Scenarios
  task reg_test;
    logic [7:0] pat [6] = '{8'ha5, 8'h5a, 8'hcc, 8'h3c, 8'hff, 8'h81};
    for (int i = 0; i < 6; i++)
      rd_chk(`WGT_IDX_WAKE_INTERVAL_LOW + 8'(i), 8'h00);
    for (int i = 0; i < 6; i++)
      wr(`WGT_IDX_WAKE_INTERVAL_LOW + 8'(i), pat[i]);
    for (int i = 0; i < 6; i++)
      rd_chk(`WGT_IDX_WAKE_INTERVAL_LOW + 8'(i), pat[i]);
    apb(1'b1, 12'h0fc, 8'h11);
    chk_val({31'h0, err}, 32'h1);
    apb(1'b0, 12'h0c1, 8'h00);
    chk_val({31'h0, err}, 32'h1);
  endtask
  task gt_run(input logic [7:0] cfg, input logic [7:0] ps,
              input logic [7:0] per, input int k, input int exp);
    int n;
    int t0;
    wr(`WGT_IDX_GP_TIMER_PRESCALE, ps);
    wr(k ? `WGT_IDX_GP_TIMER_TWO_PERIOD : `WGT_IDX_GP_TIMER_ONE_PERIOD, per);
    wr(`WGT_IDX_GP_TIMER_CONFIG, cfg);
    wait_ev(k, 2 * exp + 40, n);
    t0 = cyc;
    wr(`WGT_IDX_GP_TIMER_CONFIG, cfg);
    wait_ev(k, 2 * exp + 40, n);
    chk_span(cyc - t0, exp - 1, exp + 1);
    rd_chk(`WGT_IDX_GP_TIMER_CONFIG, cfg & ~8'h11);
  endtask
  task pause_t2;
    int n;
    gt_run(8'h30, 8'h00, 8'h05, 1, 50);
    wr(`WGT_IDX_GP_TIMER_CONFIG, 8'h30);
    repeat (15) @(posedge clk_i);
    wr(`WGT_IDX_GP_TIMER_CONFIG, 8'h20);
    wait_ev(1, 100, n);
    chk_span(n, 100, 100);
    wr(`WGT_IDX_GP_TIMER_CONFIG, 8'h30);
    wait_ev(1, 60, n);
    chk_span(n, 38, 40);
  endtask
  task wake_test;
    int n;
    int t0;
    wr(`WGT_IDX_WAKE_PRESCALE, 8'h00);
    wr(`WGT_IDX_WAKE_INTERVAL_LOW, 8'h02);
    wr(`WGT_IDX_AWAKE_HOLD_PERIOD, 8'h01);
    wr(`WGT_IDX_WAKE_CTRL, 8'h06);
    wait_ev(2, 200, n);
    t0 = cyc;
    wait_ev(3, 40, n);
    n = 0;
    while (awake_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk_span(n, 39, 41);
    wait_ev(2, 200, n);
    chk_span(cyc - t0, 59, 61);
    ext_on <= 1'b0;
    wr(`WGT_IDX_WAKE_CTRL, 8'h03);
    wait_ev(2, 400, n);
    wait_ev(2, 400, n);
    chk_span(n, 11, 13);
    wr(`WGT_IDX_WAKE_CTRL, 8'h00);
  endtask
  task irq_test;
    int n;
    wr(`WGT_IDX_INT_CLEAR, 8'h0f);
    wr(`WGT_IDX_INT_ENABLE, 8'h04);
    rd_chk(`WGT_IDX_INT_STATUS, 8'h00);
    wr(`WGT_IDX_GP_TIMER_PRESCALE, 8'h00);
    wr(`WGT_IDX_GP_TIMER_ONE_PERIOD, 8'h01);
    wr(`WGT_IDX_GP_TIMER_CONFIG, 8'h03);
    wait_ev(0, 200, n);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0, irq_o}, 32'h1);
    rd_chk(`WGT_IDX_INT_STATUS, 8'h04);
    wr(`WGT_IDX_INT_ENABLE, 8'h00);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0, irq_o}, 32'h0);
    wr(`WGT_IDX_INT_ENABLE, 8'h04);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0, irq_o}, 32'h1);
    wr(`WGT_IDX_INT_CLEAR, 8'h04);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0, irq_o}, 32'h0);
    rd_chk(`WGT_IDX_INT_STATUS, 8'h00);
    rd_chk(`WGT_IDX_INT_CLEAR, 8'h00);
  endtask
  // =====
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    ext_on <= 1'b1;
    reg_test;
    gt_run(8'h03, 8'h00, 8'h05, 0, 50);
    gt_run(8'h30, 8'h00, 8'h03, 1, 30);
    gt_run(8'h30, 8'h10, 8'h02, 1, 2560);
    gt_run(8'h30, 8'h20, 8'h01, 1, 2560);
    gt_run(8'h03, 8'h01, 8'h01, 0, 1280);
    gt_run(8'h01, 8'h00, 8'h03, 0, 60);
    gt_run(8'h10, 8'h00, 8'h02, 1, 40);
    pause_t2;
    wake_test;
    irq_test;
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    stop_test;
  end
endmodule // tb
